/* File: verification/test_sync_pll_status_and_synth_ctrl.sv */
// self-checking bench for the pll status and synthesizer control bank
`timescale 1ns/1ns
module test_sync_pll_status_and_synth_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // small system clock keeps frame periods short
  localparam int unsigned SYS_HZ = 1_000_000;

  logic       clk;
  logic       resetn;
  logic [7:0] reg_addr;
  logic       reg_wr_en;
  logic [7:0] reg_wdata;
  logic       reg_rd_en;
  logic [7:0] reg_rdata_q;
  logic [2:0] ref_fail;
  logic [3:0] first_input_rank;
  logic [3:0] second_input_rank;
  logic       auto_mode;
  logic [1:0] manual_ref_sel;
  logic       pll_holdover_in;
  logic       pll_locked_in;
  logic [1:0] active_ref_q;
  logic       ref_available_q;
  logic       synth_enable_q;
  logic       synth_clk_out_q;
  logic       synth_clk_oe_q;
  logic       synth_frame_pulse_out_q;
  logic       synth_frame_pulse_oe_q;
  int         err_total;
  int         n_compared;
  int         tg;
  int         pl;
  int         p;
  longint     lo;

  logic [7:0]  ra [6] = '{8'h25, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3E};
  logic [7:0]  rv [6] = '{8'h32, 8'h8F, 8'h0F, 8'h00, 8'h01, 8'h05};
  logic [7:0]  pw [6] = '{8'hC2, 8'h70, 8'hF0, 8'hFF, 8'hFE, 8'hFA};
  // {rank0, rank1, third rank, 0, available, active}
  logic [15:0] sel [7] = '{16'h1206, 16'h1214, 16'h1224, 16'hF216,
                           16'hF225, 16'hFF26, 16'hFFF2};
  logic [7:0]  oev [4] = '{8'h00, 8'h01, 8'h04, 8'h80};
  longint      rate [8] = '{166670, 400000, 1000000, 2000000,
                            4000000, 8000000, 32000000, 64000000};

  spsc_bank #(.SYS_CLK_HZ(SYS_HZ)) dut (
    .clk                     (clk),
    .resetn                  (resetn),
    .reg_addr                (reg_addr),
    .reg_wr_en               (reg_wr_en),
    .reg_wdata               (reg_wdata),
    .reg_rd_en               (reg_rd_en),
    .reg_rdata_q             (reg_rdata_q),
    .ref_fail                (ref_fail),
    .first_input_rank        (first_input_rank),
    .second_input_rank       (second_input_rank),
    .auto_mode               (auto_mode),
    .manual_ref_sel          (manual_ref_sel),
    .pll_holdover_in         (pll_holdover_in),
    .pll_locked_in           (pll_locked_in),
    .active_ref_q            (active_ref_q),
    .ref_available_q         (ref_available_q),
    .synth_enable_q          (synth_enable_q),
    .synth_clk_out_q         (synth_clk_out_q),
    .synth_clk_oe_q          (synth_clk_oe_q),
    .synth_frame_pulse_out_q (synth_frame_pulse_out_q),
    .synth_frame_pulse_oe_q  (synth_frame_pulse_oe_q)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // accepted window: echo the seen value, otherwise the lower bound
  function automatic int near(int got, int lo_b, int hi_b);
    return (got >= lo_b && got <= hi_b) ? got : lo_b;
  endfunction

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  // extra edge at the end so back-to-back calls never retoggle a strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(posedge clk);
    chk(what, {8'h00, exp}, {8'h00, reg_rdata_q});
  endtask

  task automatic watch(input int n, output int t, output int q);
    logic prev;
    t = 0;
    q = 0;
    // skip one edge: the pin may still show the setting just replaced
    @(posedge clk);
    prev = synth_clk_out_q;
    repeat (n) begin
      @(posedge clk);
      if (synth_clk_out_q !== prev) t++;
      if (synth_frame_pulse_out_q === 1'b1) q++;
      prev = synth_clk_out_q;
    end
  endtask

  task automatic fp_period(output int per);
    int w;
    w = 0;
    while (synth_frame_pulse_out_q !== 1'b1 && w < 8000) begin
      @(posedge clk);
      w++;
    end
    @(posedge clk);
    per = 1;
    while (synth_frame_pulse_out_q !== 1'b1 && per < 8000) begin
      @(posedge clk);
      per++;
    end
    if (w >= 8000 || per >= 8000) begin
      err_total++;
      $display("MISMATCH frame pulse wait expected pulse seen none");
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    ref_fail = 3'h0;
    first_input_rank = 4'h1;
    second_input_rank = 4'h2;
    auto_mode = 1'b0;
    manual_ref_sel = 2'h0;
    pll_holdover_in = 1'b0;
    pll_locked_in = 1'b0;
    ticks(6);
    chk("clock oe in reset", 16'h0000, {15'h0, synth_clk_oe_q});
    resetn <= 1'b1;
    ticks(2);
    chk("clock oe", 16'h0001, {15'h0, synth_clk_oe_q});
    chk("pulse oe", 16'h0001, {15'h0, synth_frame_pulse_oe_q});
    chk("synth enable", 16'h0001, {15'h0, synth_enable_q});
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], rv[i], "reset value");
    end
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], pw[i]);
      rd(ra[i], pw[i], "readback");
      wr(ra[i], rv[i]);
    end
    wr(8'h28, 8'hFF);
    rd(8'h28, 8'h00, "status after write");
    wr(8'h30, 8'h5A);
    rd(8'h30, 8'h00, "unmapped");
    // manual selection of ref1; only its failure may show
    manual_ref_sel <= 2'h1;
    for (int i = 0; i < 8; i++) begin
      pll_holdover_in <= i[0];
      pll_locked_in <= i[1];
      ref_fail <= i[2] ? 3'b010 : 3'b101;
      ticks(2);
      rd(8'h28, 8'(i), "status");
    end
    ref_fail <= 3'h0;
    for (int s = 0; s < 4; s++) begin
      manual_ref_sel <= 2'(s);
      ticks(3);
      chk("manual", (s == 3) ? 16'h2 : 16'(s), {14'h0, active_ref_q});
    end
    auto_mode <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      first_input_rank <= sel[i][15:12];
      second_input_rank <= sel[i][11:8];
      wr(8'h25, {4'h3, sel[i][7:4]});
      ticks(2);
      chk("auto ref", {14'h0, sel[i][1:0]}, {14'h0, active_ref_q});
      chk("available", {15'h0, sel[i][2]}, {15'h0, ref_available_q});
    end
    // failed inputs drop out even when ranked best
    wr(8'h25, 8'h30);
    first_input_rank <= 4'h1;
    second_input_rank <= 4'h2;
    ref_fail <= 3'b101;
    ticks(2);
    chk("failed skipped", 16'h0001, {14'h0, active_ref_q});
    chk("avail failed", 16'h0001, {15'h0, ref_available_q});
    ref_fail <= 3'h0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h36, oev[i]);
      ticks(1);
      chk("clock oe", {15'h0, oev[i][0]}, {15'h0, synth_clk_oe_q});
      chk("fp oe", {15'h0, oev[i][2]}, {15'h0, synth_frame_pulse_oe_q});
      chk("synth enable", {15'h0, oev[i][7]}, {15'h0, synth_enable_q});
    end
    // pins driven but synthesizer off: nothing may move
    wr(8'h36, 8'h05);
    watch(300, tg, pl);
    chk("toggles when off", 16'h0, 16'(tg));
    chk("pulses when off", 16'h0, 16'(pl));
    wr(8'h36, 8'h8F);
    // n of 5 gives 40 khz: 80 toggles per 1000 cycles
    wr(8'h38, 8'h05);
    wr(8'h39, 8'h00);
    watch(1000, tg, pl);
    chk("toggles n5", 16'(near(tg, 79, 81)), 16'(tg));
    wr(8'h38, 8'h0A);
    watch(1000, tg, pl);
    chk("toggles n10", 16'(near(tg, 159, 161)), 16'(tg));
    wr(8'h38, 8'h00);
    wr(8'h39, 8'h40);
    watch(1000, tg, pl);
    chk("toggles n0", 16'h0, 16'(tg));
    wr(8'h39, 8'h01);
    watch(1000, tg, pl);
    chk("toggles n256", 16'(near(tg, 990, 1000)), 16'(tg));
    wr(8'h38, 8'h05);
    wr(8'h39, 8'h00);
    wr(8'h37, 8'h0B);
    watch(300, tg, pl);
    chk("pulses stopped", 16'h0, 16'(pl));
    chk("pulse pin low", 16'h0, {15'h0, synth_frame_pulse_out_q});
    wr(8'h37, 8'h0E);
    watch(300, tg, pl);
    chk("toggles stopped", 16'h0, 16'(tg));
    chk("clock pin low", 16'h0, {15'h0, synth_clk_out_q});
    wr(8'h37, 8'h0F);
    for (int r = 0; r < 8; r++) begin
      wr(8'h3E, 8'hF8 | 8'(r));
      fp_period(p);
      fp_period(p);
      lo = longint'(SYS_HZ) * 1000 / rate[r];
      chk("frame period", 16'(near(p, int'(lo), int'(lo) + 1)), 16'(p));
    end
    conclude();
  end

endmodule // test_sync_pll_status_and_synth_ctrl

/* File: verilog/spsc_bank.sv */
// pll status and programmable synthesizer control register bank
`timescale 1ns/1ns
module spsc_bank #(
  parameter int unsigned SYS_CLK_HZ = 100_000_000
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // register port of the serial configuration interface
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr_en,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_rd_en,
  output logic      [7:0]           reg_rdata_q,
  // reference monitor and pll core
  input  wire logic [2:0]           ref_fail,
  input  wire logic [3:0]           first_input_rank,
  input  wire logic [3:0]           second_input_rank,
  input  wire logic                 auto_mode,
  input  wire logic [1:0]           manual_ref_sel,
  input  wire logic                 pll_holdover_in,
  input  wire logic                 pll_locked_in,
  // selection result
  output logic      [1:0]           active_ref_q,
  output logic                      ref_available_q,
  // synthesizer pins
  output logic                      synth_enable_q,
  output logic                      synth_clk_out_q,
  output logic                      synth_clk_oe_q,
  output logic                      synth_frame_pulse_out_q,
  output logic                      synth_frame_pulse_oe_q
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] third_ref_priority_q;
  logic [7:0] synth_output_enable_q;
  logic [7:0] synth_output_run_q;
  logic [7:0] synth_multiplier_low_q;
  logic [7:0] synth_multiplier_high_q;
  logic [7:0] frame_pulse_rate_q;

  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr_en && (reg_addr == a);
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      third_ref_priority_q <= spsc_pkg::RST_THIRD_REF_PRIORITY;
    else if (wr_hit(spsc_pkg::ADDR_THIRD_REF_PRIORITY))
      third_ref_priority_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      synth_output_enable_q <= spsc_pkg::RST_OUTPUT_ENABLE;
    else if (wr_hit(spsc_pkg::ADDR_OUTPUT_ENABLE))
      synth_output_enable_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      synth_output_run_q <= spsc_pkg::RST_OUTPUT_RUN;
    else if (wr_hit(spsc_pkg::ADDR_OUTPUT_RUN))
      synth_output_run_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      synth_multiplier_low_q <= spsc_pkg::RST_MULT_LOW;
    else if (wr_hit(spsc_pkg::ADDR_MULT_LOW))
      synth_multiplier_low_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      synth_multiplier_high_q <= spsc_pkg::RST_MULT_HIGH;
    else if (wr_hit(spsc_pkg::ADDR_MULT_HIGH))
      synth_multiplier_high_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      frame_pulse_rate_q <= spsc_pkg::RST_FP_RATE;
    else if (wr_hit(spsc_pkg::ADDR_FP_RATE))
      frame_pulse_rate_q <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference selection
  // ties between equal ranks go to the lower numbered input
  logic [3:0] third_input_rank;
  logic [3:0] rank [spsc_pkg::NUM_REFS];
  logic       best_ok;
  logic [1:0] best_idx;
  logic [3:0] best_rank;

  assign third_input_rank = third_ref_priority_q[spsc_pkg::RANK_W-1:0];

  always_comb begin
    rank[0]   = first_input_rank;
    rank[1]   = second_input_rank;
    rank[2]   = third_input_rank;
    best_ok   = 1'b0;
    best_idx  = 2'h0;
    best_rank = spsc_pkg::RANK_DISABLED;
    for (int i = 0; i < spsc_pkg::NUM_REFS; i++) begin
      if (!ref_fail[i] && rank[i] != spsc_pkg::RANK_DISABLED &&
          (!best_ok || rank[i] < best_rank)) begin
        best_ok   = 1'b1;
        best_idx  = 2'(i);
        best_rank = rank[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_ref_q    <= 2'h0;
      ref_available_q <= 1'b0;
    end else if (auto_mode) begin
      ref_available_q <= best_ok;
      if (best_ok)
        active_ref_q <= best_idx;
    end else begin
      ref_available_q <= 1'b1;
      if (manual_ref_sel != spsc_pkg::REF_SEL_INVALID)
        active_ref_q <= manual_ref_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live pll condition; writes to it are simply not decoded
  logic                      cur_fail;
  logic [spsc_pkg::STAT_W-1:0] pll_cond;

  always_comb begin
    cur_fail = ref_fail[active_ref_q];
    pll_cond = '0;
    pll_cond[spsc_pkg::STAT_HOLDOVER] = pll_holdover_in;
    pll_cond[spsc_pkg::STAT_LOCK]     = pll_locked_in;
    pll_cond[spsc_pkg::STAT_CUR_FAIL] = cur_fail;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        spsc_pkg::ADDR_THIRD_REF_PRIORITY: reg_rdata_q <= third_ref_priority_q;
        spsc_pkg::ADDR_PLL_CONDITION:
          reg_rdata_q <= 8'(pll_cond);
        spsc_pkg::ADDR_OUTPUT_ENABLE: reg_rdata_q <= synth_output_enable_q;
        spsc_pkg::ADDR_OUTPUT_RUN:    reg_rdata_q <= synth_output_run_q;
        spsc_pkg::ADDR_MULT_LOW:      reg_rdata_q <= synth_multiplier_low_q;
        spsc_pkg::ADDR_MULT_HIGH:     reg_rdata_q <= synth_multiplier_high_q;
        spsc_pkg::ADDR_FP_RATE:       reg_rdata_q <= frame_pulse_rate_q;
        default:                      reg_rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synthesizer
  spsc_pkg::spsc_ctl_t ctl;
  logic                gen_clk;
  logic                gen_fp;
  logic                synth_on;
  logic                frame_pulse_drive_enable;
  logic                frame_pulse_toggle_enable;
  logic [5:0]          multiplier_high_bits;
  logic [7:0]          multiplier_low_bits;

  always_comb begin
    synth_on                  = synth_output_enable_q[spsc_pkg::OE_SYNTH_BIT];
    frame_pulse_drive_enable  = synth_output_enable_q[spsc_pkg::OE_FP_BIT];
    frame_pulse_toggle_enable = synth_output_run_q[spsc_pkg::RUN_FP_BIT];
    multiplier_high_bits      =
      synth_multiplier_high_q[spsc_pkg::MULT_HIGH_W-1:0];
    multiplier_low_bits       = synth_multiplier_low_q;
    ctl.synth_on = synth_on;
    ctl.clk_run  = synth_output_run_q[spsc_pkg::RUN_CLK_BIT];
    ctl.fp_run   = frame_pulse_toggle_enable;
    ctl.mult     = {multiplier_high_bits, multiplier_low_bits};
    ctl.fp_rate  = frame_pulse_rate_q[spsc_pkg::RATE_W-1:0];
  end

  spsc_synth_gen #(
    .SYS_CLK_HZ (SYS_CLK_HZ)
  ) u_gen (
    .clk        (clk),
    .resetn     (resetn),
    .ctl        (ctl),
    .clk_tgl_q  (gen_clk),
    .fp_pulse_q (gen_fp)
  );

  // pins are gated here too so a control change shows the next cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      synth_enable_q          <= 1'b0;
      synth_clk_out_q         <= 1'b0;
      synth_clk_oe_q          <= 1'b0;
      synth_frame_pulse_out_q <= 1'b0;
      synth_frame_pulse_oe_q  <= 1'b0;
    end else begin
      synth_enable_q          <= synth_on;
      synth_clk_out_q         <= synth_on && ctl.clk_run && gen_clk;
      synth_clk_oe_q          <=
        synth_output_enable_q[spsc_pkg::OE_CLK_BIT];
      synth_frame_pulse_out_q <=
        synth_on && frame_pulse_toggle_enable && gen_fp;
      synth_frame_pulse_oe_q  <= frame_pulse_drive_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_cond_read;
    reg_rd_en && reg_addr == spsc_pkg::ADDR_PLL_CONDITION;
  endsequence

  sequence s_third_wins;
    auto_mode && !ref_fail[2] && third_input_rank == 4'h0 &&
    first_input_rank != 4'h0 && second_input_rank != 4'h0;
  endsequence

  rank_pick_a: assert property (@(posedge clk) disable iff (!resetn)
    s_third_wins |=> active_ref_q == spsc_pkg::THIRD_REF)
    else $error("top ranked third reference not chosen");

  rank_off_a: assert property (@(posedge clk) disable iff (!resetn)
    auto_mode && third_input_rank == spsc_pkg::RANK_DISABLED &&
    active_ref_q != spsc_pkg::THIRD_REF
    |=> active_ref_q != spsc_pkg::THIRD_REF)
    else $error("disabled third reference chosen");

  hold_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    s_cond_read |=> reg_rdata_q[0] == $past(pll_holdover_in))
    else $error("holdover bit wrong");

  lock_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    s_cond_read |=> reg_rdata_q[1] == $past(pll_locked_in))
    else $error("lock bit wrong");

  fail_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    s_cond_read |=> reg_rdata_q[2] == $past(cur_fail))
    else $error("current reference fail bit wrong");

  cond_rsvd_a: assert property (@(posedge clk) disable iff (!resetn)
    s_cond_read |=> reg_rdata_q[7:3] == 5'h00)
    else $error("status reserved bits not zero");

  reset_vals_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> synth_output_enable_q == 8'h8F &&
    synth_output_run_q == 8'h0F && ctl.mult == 14'h100 &&
    ctl.fp_rate == 3'h5)
    else $error("control reset values wrong");

  clk_hiz_a: assert property (@(posedge clk) disable iff (!resetn)
    !synth_output_enable_q[0] |=> !synth_clk_oe_q)
    else $error("synth clock driven while disabled");

  fp_hiz_a: assert property (@(posedge clk) disable iff (!resetn)
    synth_output_enable_q[2] ##1 !synth_output_enable_q[2]
    |=> !synth_frame_pulse_oe_q)
    else $error("frame pulse driven while disabled");

  synth_off_a: assert property (@(posedge clk) disable iff (!resetn)
    !synth_output_enable_q[7] [*2] |=> !synth_clk_out_q &&
    !synth_frame_pulse_out_q && !synth_enable_q)
    else $error("outputs active with synthesizer off");

  clk_low_a: assert property (@(posedge clk) disable iff (!resetn)
    !synth_output_run_q[0] |=> !synth_clk_out_q)
    else $error("synth clock not held low");

  fp_low_a: assert property (@(posedge clk) disable iff (!resetn)
    !synth_output_run_q[2] |=> !synth_frame_pulse_out_q)
    else $error("frame pulse not held low");

  mult_low_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_hit(spsc_pkg::ADDR_MULT_LOW)
    |=> ctl.mult[7:0] == $past(reg_wdata))
    else $error("multiplier low bits not loaded");

  manual_sel_a: assert property (@(posedge clk) disable iff (!resetn)
    !auto_mode && manual_ref_sel != spsc_pkg::REF_SEL_INVALID
    |=> active_ref_q == $past(manual_ref_sel))
    else $error("manual reference select ignored");

endmodule // spsc_bank

/* File: verilog/spsc_pkg.sv */
// shared constants and types for the pll status and synthesizer control bank
package spsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_THIRD_REF_PRIORITY = 8'h25;
  localparam logic [7:0] ADDR_PLL_CONDITION      = 8'h28;
  localparam logic [7:0] ADDR_OUTPUT_ENABLE      = 8'h36;
  localparam logic [7:0] ADDR_OUTPUT_RUN         = 8'h37;
  localparam logic [7:0] ADDR_MULT_LOW           = 8'h38;
  localparam logic [7:0] ADDR_MULT_HIGH          = 8'h39;
  localparam logic [7:0] ADDR_FP_RATE            = 8'h3E;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_THIRD_REF_PRIORITY  = 8'h32;
  localparam logic [7:0] RST_OUTPUT_ENABLE       = 8'h8F;
  localparam logic [7:0] RST_OUTPUT_RUN          = 8'h0F;
  localparam logic [7:0] RST_MULT_LOW            = 8'h00;
  localparam logic [7:0] RST_MULT_HIGH           = 8'h01;
  localparam logic [7:0] RST_FP_RATE             = 8'h05;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and widths
  localparam int RANK_W           = 4;
  localparam int STAT_HOLDOVER    = 0;
  localparam int STAT_LOCK        = 1;
  localparam int STAT_CUR_FAIL    = 2;
  localparam int STAT_W           = 3;
  localparam int OE_CLK_BIT       = 0;
  localparam int OE_FP_BIT        = 2;
  localparam int OE_SYNTH_BIT     = 7;
  localparam int RUN_CLK_BIT      = 0;
  localparam int RUN_FP_BIT       = 2;
  localparam int MULT_W           = 14;
  localparam int MULT_HIGH_W      = 6;
  localparam int RATE_W           = 3;
  localparam int REF_SEL_W        = 2;
  localparam int NUM_REFS         = 3;

  localparam logic [3:0] RANK_DISABLED   = 4'hF;
  localparam logic [1:0] REF_SEL_INVALID = 2'h3;
  localparam logic [1:0] THIRD_REF       = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing: synthesizer step in hertz, frame pulse rates in millihertz
  localparam longint unsigned MULT_STEP_HZ = 8000;
  localparam longint unsigned FP_RATE_MHZ [8] = '{
    166670, 400000, 1000000, 2000000,
    4000000, 8000000, 32000000, 64000000};

  ////////////////////////////////////////////////////////////////////////////
  // synthesizer control carried to the generator
  typedef struct packed {
    logic                 synth_on;
    logic                 clk_run;
    logic                 fp_run;
    logic [MULT_W-1:0]    mult;
    logic [RATE_W-1:0]    fp_rate;
  } spsc_ctl_t;

endpackage

/* File: verilog/spsc_synth_gen.sv */
// programmable synthesizer clock and frame pulse generator
`timescale 1ns/1ns
module spsc_synth_gen #(
  parameter int unsigned SYS_CLK_HZ = 100_000_000
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // control
  input  spsc_pkg::spsc_ctl_t    ctl,
  // generated signals
  output logic                   clk_tgl_q,
  output logic                   fp_pulse_q
);

  localparam logic [32:0] HZ = 33'(SYS_CLK_HZ);

  function automatic logic [31:0] fp_period(input logic [2:0] sel);
    longint unsigned p;
    p = (longint'(SYS_CLK_HZ) * 1000) / spsc_pkg::FP_RATE_MHZ[sel];
    if (p < 2)
      p = 2;
    return p[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // phase accumulator: toggles at twice n times 8 khz
  // limitation: rates above half the system clock saturate
  logic [31:0] acc_q;
  logic [32:0] step;
  logic [32:0] sum;

  always_comb begin
    step = 33'(ctl.mult) * 33'(2 * spsc_pkg::MULT_STEP_HZ);
    if (step >= HZ)
      step = HZ - 33'h1;
    sum = {1'b0, acc_q} + step;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q     <= 32'h0;
      clk_tgl_q <= 1'b0;
    end else if (!ctl.synth_on || !ctl.clk_run) begin
      acc_q     <= 32'h0;
      clk_tgl_q <= 1'b0;
    end else if (sum >= HZ) begin
      acc_q     <= 32'(sum - HZ);
      clk_tgl_q <= ~clk_tgl_q;
    end else begin
      acc_q     <= sum[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame pulse: one system clock wide, once per selected period
  logic [31:0] fp_cnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fp_cnt_q   <= 32'h0;
      fp_pulse_q <= 1'b0;
    end else if (!ctl.synth_on) begin
      fp_cnt_q   <= 32'h0;
      fp_pulse_q <= 1'b0;
    end else if (fp_cnt_q >= fp_period(ctl.fp_rate) - 32'h1) begin
      fp_cnt_q   <= 32'h0;
      fp_pulse_q <= ctl.fp_run;
    end else begin
      fp_cnt_q   <= fp_cnt_q + 32'h1;
      fp_pulse_q <= 1'b0;
    end
  end

  fp_one_wide_a: assert property (@(posedge clk) disable iff (!resetn)
    fp_pulse_q |=> !fp_pulse_q)
    else $error("frame pulse wider than one clock");

endmodule // spsc_synth_gen
